// File: irq_regs_pkg.sv
//==========================================================================
// Summary of operation
//==========================================================================
package irq_regs_pkg;

  //========================================================================
  // Register map
  //========================================================================
  localparam logic [7:0] ENABLE_ADDR   = 8'ha8; // Enable register
  localparam logic [7:0] PRIO_ADDR     = 8'hb8; // Priority register
  localparam logic [7:0] PRIO_PAGE     = 8'h00; // Only page for priority
  localparam logic [7:0] ENABLE_RESET  = 8'h00; // Enable after reset
  localparam logic [7:0] PRIO_RESET    = 8'h80; // Priority after reset
  localparam logic [7:0] PRIO_RO_MASK  = 8'h80; // Bit that reads one

  //========================================================================
  // Field positions
  //========================================================================
  localparam int GLOBAL_EN_BIT  = 7; // Global enable
  localparam int SERIAL_PERIPH_PORT0_BIT       = 6; // Serial peripheral port 0
  localparam int TMR2_BIT       = 5; // Timer 2
  localparam int ASYNC_SERIAL_PORT0_BIT      = 4; // Async serial port 0
  localparam int TMR1_BIT       = 3; // Timer 1
  localparam int EXT1_BIT       = 2; // External interrupt 1
  localparam int TMR0_BIT       = 1; // Timer 0
  localparam int EXT0_BIT       = 0; // External interrupt 0
  localparam int NUM_SOURCES    = 7; // Sources handled here

endpackage : irq_regs_pkg

// File: irq_pick.sv
`timescale 1ns/10ps
`default_nettype none
//==========================================================================
// Lowest-index picker over a request vector
//==========================================================================
module irq_pick #(
  parameter int N = 7
) (
  // Requests
  input  wire logic [N-1:0]         req,
  // Result
  output logic                      hit,
  output logic [$clog2(N)-1:0]      idx
);
  initial begin
    if (N < 2) $error("irq_pick needs at least two sources");
  end

  // Lowest index wins, matching the fixed source order
  always_comb begin
    hit = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        hit = 1'b1;
        idx = i[$clog2(N)-1:0];
      end
    end
  end
endmodule : irq_pick
`default_nettype wire

// File: irq_enable_prio.sv
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
//==========================================================================
// Interrupt enable and priority registers with request arbiter
//==========================================================================
module irq_enable_prio #(
  parameter int NSRC = 7
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_page,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic                 reg_bit_mode,
  input  wire logic [2:0]           reg_bit_sel,
  output logic [7:0]                reg_rdata,
  // Pending flags from the peripherals
  input  wire logic                 ext_irq0_input,
  input  wire logic                 timer0_overflow_flag,
  input  wire logic                 ext_irq1_input,
  input  wire logic                 timer1_overflow_flag,
  input  wire logic                 async_port0_irq,
  input  wire logic                 timer2_low_overflow_flag,
  input  wire logic                 timer2_high_overflow_flag,
  input  wire logic                 serial_periph0_irq,
  // Request towards the core
  output logic                      irq_req,
  output logic [2:0]                irq_src,
  output logic                      irq_high,
  // Register views
  output logic [7:0]                enable_q,
  output logic [7:0]                prio_q
);

  //========================================================================
  // Elaboration checks
  //========================================================================
  initial begin
    if (NSRC != irq_regs_pkg::NUM_SOURCES)
      $error("irq_enable_prio serves exactly seven sources");
  end

  //========================================================================
  // State
  //========================================================================
  typedef struct packed {
    logic [7:0] enable_r;   // Enable register
    logic [6:0] prio_r;     // Writable priority bits
    logic [7:0] rdata_r;    // Read data, valid one cycle after strobe
    logic       req_r;      // Request to core
    logic [2:0] src_r;      // Winning source index
    logic       high_r;     // Winner is high level
  } state_s;

  state_s st_r;             // Registered state
  state_s st_nxt;           // Next state

  logic [NSRC-1:0] pend;    // Raw pending per source
  logic [NSRC-1:0] live;    // Pending and allowed
  logic [NSRC-1:0] prio_v;  // Level per source
  logic [NSRC-1:0] hi_req;  // High level candidates
  logic [NSRC-1:0] lo_req;  // Low level candidates
  logic            hi_hit;  // Any high candidate
  logic            lo_hit;  // Any low candidate
  logic [2:0]      hi_idx;  // First high candidate
  logic [2:0]      lo_idx;  // First low candidate
  logic            en_sel;  // Enable register addressed
  logic            pr_sel;  // Priority register addressed
  logic [7:0]      prio_rd; // Priority as read back
  logic [7:0]      bit_msk; // Single-bit write mask

  //========================================================================
  // Request gating
  //========================================================================
  // Levels are not latched here: a flag held while masked shows up the
  // cycle after both its mask and the global enable are set
  always_comb begin
    pend = '0;
    pend[irq_regs_pkg::EXT0_BIT]  = ext_irq0_input;
    pend[irq_regs_pkg::TMR0_BIT]  = timer0_overflow_flag;
    pend[irq_regs_pkg::EXT1_BIT]  = ext_irq1_input;
    pend[irq_regs_pkg::TMR1_BIT]  = timer1_overflow_flag;
    pend[irq_regs_pkg::ASYNC_SERIAL_PORT0_BIT] = async_port0_irq;
    // Either timer 2 half raises the same request
    pend[irq_regs_pkg::TMR2_BIT]  = timer2_low_overflow_flag |
                                    timer2_high_overflow_flag;
    pend[irq_regs_pkg::SERIAL_PERIPH_PORT0_BIT]  = serial_periph0_irq;
    // Per-source masks, then the global override
    live = pend & st_r.enable_r[NSRC-1:0];
    if (!st_r.enable_r[irq_regs_pkg::GLOBAL_EN_BIT]) begin
      live = '0;
    end
  end

  //========================================================================
  // Priority split
  //========================================================================
  // Bit set places the source at high level
  assign prio_v = st_r.prio_r;
  assign hi_req = live & prio_v;
  assign lo_req = live & ~prio_v;

  // Fixed order inside each level
  irq_pick #(.N(NSRC)) u_pick_hi (
    .req (hi_req),
    .hit (hi_hit),
    .idx (hi_idx)
  );

  irq_pick #(.N(NSRC)) u_pick_lo (
    .req (lo_req),
    .hit (lo_hit),
    .idx (lo_idx)
  );

  //========================================================================
  // Address decode
  //========================================================================
  always_comb begin
    en_sel = 1'b0;
    pr_sel = 1'b0;
    if (reg_addr == irq_regs_pkg::ENABLE_ADDR) begin
      en_sel = 1'b1;
    end else if (reg_addr == irq_regs_pkg::PRIO_ADDR &&
                 reg_page == irq_regs_pkg::PRIO_PAGE) begin
      pr_sel = 1'b1;
    end
  end

  // Unused top bit always reads one
  assign prio_rd = irq_regs_pkg::PRIO_RO_MASK | {1'b0, st_r.prio_r};
  assign bit_msk = 8'h01 << reg_bit_sel;

  //========================================================================
  // Next state
  //========================================================================
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata_r = 8'h00;
    // Writes: whole byte or one bit
    if (reg_wr && en_sel) begin
      if (reg_bit_mode) begin
        st_nxt.enable_r = (st_r.enable_r & ~bit_msk) |
                          (reg_wdata[0] ? bit_msk : 8'h00);
      end else begin
        st_nxt.enable_r = reg_wdata;
      end
    end else if (reg_wr && pr_sel) begin
      // Top bit has no storage, so writes to it vanish
      if (reg_bit_mode) begin
        st_nxt.prio_r = (st_r.prio_r & ~bit_msk[6:0]) |
                        (reg_wdata[0] ? bit_msk[6:0] : 7'h00);
      end else begin
        st_nxt.prio_r = reg_wdata[6:0];
      end
    end
    // Reads: byte or single bit in bit 0; unmapped reads zero
    if (reg_rd) begin
      if (en_sel) begin
        st_nxt.rdata_r = reg_bit_mode ?
          {7'h00, st_r.enable_r[reg_bit_sel]} : st_r.enable_r;
      end else if (pr_sel) begin
        st_nxt.rdata_r = reg_bit_mode ?
          {7'h00, prio_rd[reg_bit_sel]} : prio_rd;
      end
    end
    // Arbitration: high level beats low, then fixed order
    if (hi_hit) begin
      st_nxt.req_r  = 1'b1;
      st_nxt.src_r  = hi_idx;
      st_nxt.high_r = 1'b1;
    end else if (lo_hit) begin
      st_nxt.req_r  = 1'b1;
      st_nxt.src_r  = lo_idx;
      st_nxt.high_r = 1'b0;
    end else begin
      st_nxt.req_r  = 1'b0;
      st_nxt.src_r  = 3'h0;
      st_nxt.high_r = 1'b0;
    end
  end

  //========================================================================
  // State register
  //========================================================================
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r.enable_r <= irq_regs_pkg::ENABLE_RESET;
      st_r.prio_r   <= irq_regs_pkg::PRIO_RESET[6:0];
      st_r.rdata_r  <= 8'h00;
      st_r.req_r    <= 1'b0;
      st_r.src_r    <= 3'h0;
      st_r.high_r   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  //========================================================================
  // Outputs
  //========================================================================
  assign reg_rdata = st_r.rdata_r;
  assign irq_req   = st_r.req_r;
  assign irq_src   = st_r.src_r;
  assign irq_high  = st_r.high_r;
  assign enable_q  = st_r.enable_r;
  assign prio_q    = {1'b1, st_r.prio_r};

endmodule : irq_enable_prio
`default_nettype wire

// File: irq_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// Checker on the enable, priority and request ports
module irq_regs_sva #(
  parameter int NSRC = 7
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Register port
  input wire logic [7:0] reg_addr, reg_page, reg_wdata, reg_rdata,
  input wire logic       reg_wr, reg_rd, reg_bit_mode,
  input wire logic [2:0] reg_bit_sel, irq_src,
  // Pending flags, request and register views
  input wire logic       ext_irq0_input, timer0_overflow_flag,
  input wire logic       ext_irq1_input, timer1_overflow_flag,
  input wire logic       async_port0_irq, serial_periph0_irq,
  input wire logic       timer2_low_overflow_flag, timer2_high_overflow_flag,
  input wire logic       irq_req, irq_high,
  input wire logic [7:0] enable_q, prio_q
);
  logic [6:0] pend; // Pending per source index
  logic [6:0] al;   // Pending after both masks
  logic [2:0] win;  // Expected winner
  // Lowest index wins; the second pass lets high level override
  always_comb begin
    pend = {serial_periph0_irq,
            timer2_low_overflow_flag | timer2_high_overflow_flag,
            async_port0_irq, timer1_overflow_flag, ext_irq1_input,
            timer0_overflow_flag, ext_irq0_input};
    al = enable_q[7] ? (pend & enable_q[6:0]) : 7'h00;
    win = 3'h0;
    for (int i = 6; i >= 0; i--) if (al[i]) win = 3'(i);
    for (int i = 6; i >= 0; i--) if (al[i] && prio_q[i]) win = 3'(i);
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Whole-byte writes
  sequence s_en_wr;
    reg_wr && !reg_bit_mode && reg_addr == 8'ha8;
  endsequence
  sequence s_pr_wr;
    reg_wr && !reg_bit_mode && reg_addr == 8'hb8 && reg_page == 8'h00;
  endsequence
  AST_GLOBAL_OFF: assert property (!enable_q[7] |=> !irq_req)
    else $error("request with global enable clear");
  AST_REQ: assert property (1 |=> irq_req == $past(|al))
    else $error("request differs from masked pending");
  AST_SRC: assert property (1 |=> irq_src == $past(win))
    else $error("wrong winning source");
  AST_HIGH: assert property
    (1 |=> irq_high == $past(|(al & prio_q[6:0])))
    else $error("wrong priority level");
  AST_PRIO7: assert property (prio_q[7])
    else $error("priority bit 7 not one");
  AST_EN_WR: assert property (s_en_wr |=> enable_q == $past(reg_wdata))
    else $error("enable write lost");
  AST_PR_WR: assert property
    (s_pr_wr |=> prio_q == ($past(reg_wdata) | 8'h80))
    else $error("priority write wrong");
  AST_OFF_PAGE: assert property
    (reg_wr && reg_addr == 8'hb8 && reg_page != 8'h00 |=> $stable(prio_q))
    else $error("priority written off page");
  AST_BIT_WR: assert property
    (reg_wr && reg_bit_mode && reg_addr == 8'ha8
     |=> enable_q[$past(reg_bit_sel)] == $past(reg_wdata[0]))
    else $error("enable bit write lost");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule : irq_regs_sva
bind irq_enable_prio irq_regs_sva #(.NSRC(NSRC)) irq_regs_sva_i (.*);
`default_nettype wire

// File: irq_src_model.sv
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// Peripherals: pending flags held as levels until cleared
module irq_src_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Set and clear pulses from the bench
  input  wire logic [7:0] set_v,
  input  wire logic [7:0] clr_v,
  // Flags towards the block
  output logic [7:0]      flag
);
  // Set wins over clear, so a new event is never lost
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) flag <= 8'h00;
    else flag <= (flag & ~clr_v) | set_v;
  end
endmodule : irq_src_model
`default_nettype wire

// File: test_irq_enable_prio.sv
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// Random register traffic and flags against a bench model
module test_irq_enable_prio;
  logic       clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       reg_bit_mode = 1'b0, irq_req, irq_high;
  logic [7:0] reg_addr = 8'h00, reg_page = 8'h00, reg_wdata = 8'h00;
  logic [7:0] set_v = 8'h00, clr_v = 8'h00, flag, reg_rdata, enable_q, prio_q;
  logic [2:0] reg_bit_sel = 3'h0, irq_src;
  logic [7:0] m_en = 8'h00, m_pr = 8'h80, m_fl = 8'h00; // Bench model
  logic [31:0] r, q;
  integer     seed = 32'h1af0acc8, bad_count = 0, samples_checked = 0;
  integer     cyc = 0;
  always #25 clk_sys = ~clk_sys;
  irq_enable_prio #(.NSRC(7)) irq_enable_prio_i (.clk_sys(clk_sys),
    .reset(reset), .reg_addr(reg_addr), .reg_page(reg_page),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_bit_mode(reg_bit_mode), .reg_bit_sel(reg_bit_sel),
    .reg_rdata(reg_rdata), .ext_irq0_input(flag[0]),
    .timer0_overflow_flag(flag[1]), .ext_irq1_input(flag[2]),
    .timer1_overflow_flag(flag[3]), .async_port0_irq(flag[4]),
    .timer2_low_overflow_flag(flag[5]), .timer2_high_overflow_flag(flag[6]),
    .serial_periph0_irq(flag[7]), .irq_req(irq_req), .irq_src(irq_src),
    .irq_high(irq_high), .enable_q(enable_q), .prio_q(prio_q));
  irq_src_model irq_src_model_i (.clk_sys(clk_sys), .reset(reset),
    .set_v(set_v), .clr_v(clr_v), .flag(flag));
  task report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task cmp_rd(input logic [7:0] e);
    samples_checked++;
    if (reg_rdata !== e) begin
      bad_count++;
      $display("Error %0t read %h expected %h", $time, reg_rdata, e);
    end
  endtask : cmp_rd
  task cmp_irq(input logic [4:0] e);
    samples_checked++;
    if ({irq_req, irq_src, irq_high} !== e) begin
      bad_count++;
      $display("Error %0t request %b expected %b", $time,
               {irq_req, irq_src, irq_high}, e);
    end
  endtask : cmp_irq
  // Register views against the bench model
  task cmp_reg(input logic [15:0] e);
    samples_checked++;
    if ({enable_q, prio_q} !== e) begin
      bad_count++;
      $display("Error %0t registers %h expected %h", $time,
               {enable_q, prio_q}, e);
    end
  endtask : cmp_reg
  // Model answer: lowest index at the highest level present
  function automatic logic [4:0] exp_irq();
    logic [6:0] p, a;
    int w;
    p = {m_fl[7], m_fl[6] | m_fl[5], m_fl[4:0]};
    a = m_en[7] ? (p & m_en[6:0]) : 7'h00;
    w = 0;
    for (int i = 6; i >= 0; i--) if (a[i]) w = i;
    for (int i = 6; i >= 0; i--) if (a[i] && m_pr[i]) w = i;
    return {|a, 3'(w), |(a & m_pr[6:0])};
  endfunction : exp_irq
  // One write or read; read data are looked at in their single cycle
  task acc(input logic wr, input logic [7:0] a, pg, d,
           input logic bm, input logic [2:0] bs);
    logic [7:0] e;
    e = 8'h00;
    if (a == 8'ha8) e = bm ? {7'h00, m_en[bs]} : m_en;
    if (a == 8'hb8 && pg == 8'h00) e = bm ? {7'h00, m_pr[bs]} : m_pr;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_page <= pg;
    reg_wdata <= d;
    reg_bit_mode <= bm;
    reg_bit_sel <= bs;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    if (wr && a == 8'ha8 && bm) m_en[bs] = d[0];
    if (wr && a == 8'ha8 && !bm) m_en = d;
    if (wr && a == 8'hb8 && pg == 8'h00 && bm) m_pr[bs] = d[0];
    if (wr && a == 8'hb8 && pg == 8'h00 && !bm) m_pr = d;
    m_pr[7] = 1'b1;
    #1;
    if (!wr) cmp_rd(e);
  endtask : acc
  // Timeout: far above the roughly 1800 cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    acc(1'b0, 8'ha8, 8'h05, 8'h00, 1'b0, 3'h0);
    acc(1'b0, 8'hb8, 8'h00, 8'h00, 1'b0, 3'h0);
    repeat (300) begin
      r = $random(seed);
      q = $random(seed);
      acc(r[2], r[1:0] == 2'h0 ? r[15:8] : (r[1] ? 8'hb8 : 8'ha8),
          r[16] ? 8'h00 : r[31:24], r[23:16], r[3], r[6:4]);
      @(posedge clk_sys);
      set_v <= q[7:0] & q[15:8];
      clr_v <= q[23:16] & q[31:24];
      @(posedge clk_sys);
      set_v <= 8'h00;
      clr_v <= 8'h00;
      m_fl = (m_fl & ~(q[23:16] & q[31:24])) | (q[7:0] & q[15:8]);
      repeat (2) @(posedge clk_sys);
      #1;
      cmp_irq(exp_irq());
      cmp_reg({m_en, m_pr});
    end
    report_and_stop;
  end
endmodule : test_irq_enable_prio
`default_nettype wire
